// *** sswm_pkg.sv ***
// How it works
// R1: on enable, drive a signed bias -100..100 percent, default 0, live updates.
// R2: position mode: in-position after error below threshold for 1 ms.
// R3: position mode: near-position while error below threshold, no delay.
// R4: position, speed, third mode: speed window after 10 ms below threshold.
// R5: any mode: up-to-speed while motor speed above threshold.
// R6: speed mode: analog command below clamp magnitude is forced to zero.
// R7: brake released after delay from enable; delay latched only while servo off.
// R8: outputs drop at once when condition lost; timers restart then.
package sswm_pkg;

  // ****************************************
  // operating modes
  // ****************************************
  typedef enum logic [1:0] {
    SSWM_MODE_POS    = 2'b00,
    SSWM_MODE_SPEED  = 2'b01,
    SSWM_MODE_TORQUE = 2'b10,
    SSWM_MODE_OTHER  = 2'b11
  } sswm_mode_t;

  // ****************************************
  // defaults and limits
  // ****************************************
  localparam logic signed [7:0] SSWM_BIAS_RST   = 8'sh00;
  localparam logic signed [7:0] SSWM_BIAS_MAX   = 8'sh64;
  localparam logic signed [7:0] SSWM_BIAS_MIN   = -8'sh64;
  localparam logic [11:0] SSWM_INPOS_RST        = 12'h00a;
  localparam logic [11:0] SSWM_NEAR_RST         = 12'h014;
  localparam logic [9:0]  SSWM_WIN_RST          = 10'h00a;
  localparam logic [12:0] SSWM_UTS_RST          = 13'h0014;
  localparam logic [12:0] SSWM_CLAMP_RST        = 13'h0000;
  localparam logic [13:0] SSWM_BRAKE_RST        = 14'h0000;

  // ****************************************
  // timing
  // ****************************************
  localparam int SSWM_CLK_HZ      = 25_000_000;
  localparam int SSWM_TICK_MS     = 1;
  localparam int SSWM_TICK_CYC    = SSWM_CLK_HZ / 1000 * SSWM_TICK_MS;
  localparam int SSWM_INPOS_MS    = 1;
  localparam int SSWM_WIN_MS      = 10;

endpackage : sswm_pkg

// *** sswm_tick_if.sv ***
`timescale 1ns/10ps
// carries the millisecond tick between the divider and the monitor
interface sswm_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input  tick);
endinterface : sswm_tick_if

// *** sswm_tick_gen.sv ***
`timescale 1ns/10ps
module sswm_tick_gen #(
  parameter int TICK_CYC = sswm_pkg::SSWM_TICK_CYC
) (
  // clock and reset
  input  wire logic  sys_clk_i,
  input  wire logic  rst_i,
  // tick out
  sswm_tick_if.src   tick_o
);

  logic [31:0] cnt_q;
  logic        tick_q;

  // free running divider, one pulse each millisecond
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (cnt_q == 32'(TICK_CYC - 1)) begin
      cnt_q  <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  assign tick_o.tick = tick_q;

endmodule : sswm_tick_gen

// *** sswm_monitor.sv ***
`timescale 1ns/10ps
module sswm_monitor #(
  parameter int TICK_CYC = sswm_pkg::SSWM_TICK_CYC
) (
  // clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               rst_i,
  // drive state
  input  wire sswm_pkg::sswm_mode_t mode_i,
  input  wire logic               enable_i,
  // measured quantities
  input  wire logic signed [31:0] pos_err_i,
  input  wire logic signed [15:0] speed_err_i,
  input  wire logic signed [15:0] motor_speed_i,
  input  wire logic signed [15:0] analog_cmd_i,
  // settings
  input  wire logic signed [7:0]  initial_bias_param_i,
  input  wire logic [11:0]        in_position_size_param_i,
  input  wire logic [11:0]        near_position_size_param_i,
  input  wire logic [9:0]         speed_window_param_i,
  input  wire logic [12:0]        up_to_speed_param_i,
  input  wire logic [12:0]        zero_clamp_param_i,
  input  wire logic [13:0]        brake_release_delay_param_i,
  // output assignment enables
  input  wire logic               in_pos_assigned_i,
  input  wire logic               near_pos_assigned_i,
  input  wire logic               win_assigned_i,
  input  wire logic               uts_assigned_i,
  // status outputs
  output logic                    in_position_o,
  output logic                    near_position_o,
  output logic                    within_window_o,
  output logic                    up_to_speed_o,
  // command and actuation outputs
  output logic signed [15:0]      speed_cmd_o,
  output logic signed [7:0]       bias_o,
  output logic                    brake_release_o
);

  // ****************************************
  // helpers
  // ****************************************
  // the result is unsigned, so the most negative input still gives its true
  // size rather than wrapping back to a negative number
  function automatic logic [31:0] mag32(input logic signed [31:0] v);
    mag32 = v[31] ? 32'(-v) : 32'(v);
  endfunction : mag32

  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    mag16 = v[15] ? 16'(-v) : 16'(v);
  endfunction : mag16

  sswm_tick_if tick_bus ();

  sswm_tick_gen #(.TICK_CYC(TICK_CYC)) u_tick (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .tick_o    (tick_bus)
  );

  // one pulse per millisecond, shared by both timers and the brake delay;
  // the divider runs from reset rather than from each condition, so the
  // first tick after a condition starts can come on any edge
  logic ms_tick;
  assign ms_tick = tick_bus.tick;

  // ****************************************
  // compare conditions
  // ****************************************
  logic pos_mode, win_mode, spd_mode;
  logic in_cond, near_cond, win_cond, uts_cond;

  // errors compare by magnitude, so a deviation of either sign qualifies;
  // every compare is strict, so a zero error threshold keeps that output off,
  // and an output that is not assigned never asserts whatever its condition
  // the window check covers position, speed and torque, never the spare mode
  assign pos_mode  = (mode_i == sswm_pkg::SSWM_MODE_POS);
  assign spd_mode  = (mode_i == sswm_pkg::SSWM_MODE_SPEED);
  assign win_mode  = pos_mode | spd_mode | (mode_i == sswm_pkg::SSWM_MODE_TORQUE);
  assign in_cond   = pos_mode & in_pos_assigned_i
                   & (mag32(pos_err_i) < {20'h0_0000, in_position_size_param_i});
  assign near_cond = pos_mode & near_pos_assigned_i
                   & (mag32(pos_err_i) < {20'h0_0000, near_position_size_param_i}); // R3
  assign win_cond  = win_mode & win_assigned_i
                   & (mag16(speed_err_i) < {6'h00, speed_window_param_i});
  assign uts_cond  = uts_assigned_i
                   & (mag16(motor_speed_i) > {3'h0, up_to_speed_param_i}); // R5

  // ****************************************
  // qualification timers
  // ****************************************
  // a tick on the very edge where the condition starts would count a partial
  // millisecond, so one extra tick is demanded; the wait is then between n and
  // n+1 ms, never shorter than n
  // the counters stop at their end value, so a long stay never wraps
  localparam logic [4:0] IN_DONE  = 5'(sswm_pkg::SSWM_INPOS_MS + 1);
  localparam logic [4:0] WIN_DONE = 5'(sswm_pkg::SSWM_WIN_MS + 1);
  logic [4:0] in_cnt_q, win_cnt_q;
  logic       in_pos_q, win_q;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_cnt_q <= 5'h00;
      in_pos_q <= 1'b0;
    end else if (!in_cond) begin
      in_cnt_q <= 5'h00; // R8
      in_pos_q <= 1'b0;  // R8
    end else if (ms_tick && in_cnt_q != IN_DONE) begin
      in_cnt_q <= in_cnt_q + 5'h01;
      in_pos_q <= (in_cnt_q + 5'h01) == IN_DONE; // R2
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      win_cnt_q <= 5'h00;
      win_q     <= 1'b0;
    end else if (!win_cond) begin
      win_cnt_q <= 5'h00; // R8
      win_q     <= 1'b0;  // R8
    end else if (ms_tick && win_cnt_q != WIN_DONE) begin
      win_cnt_q <= win_cnt_q + 5'h01;
      win_q     <= (win_cnt_q + 5'h01) == WIN_DONE; // R4
    end
  end

  // direct status flops; near position and up to speed have no
  // qualification time and simply follow their condition one cycle later
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      near_position_o <= 1'b0;
      up_to_speed_o   <= 1'b0;
    end else begin
      near_position_o <= near_cond; // R3
      up_to_speed_o   <= uts_cond;  // R5
    end
  end

  // mask the timed flags so a lost condition drops the output on the next edge, with the flag, not one edge after it
  // the mask also drops them at once when the mode leaves its set
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_position_o   <= 1'b0;
      within_window_o <= 1'b0;
    end else begin
      in_position_o   <= in_pos_q & in_cond; // R8
      within_window_o <= win_q & win_cond;   // R8
    end
  end

  // ****************************************
  // zero clamp
  // ****************************************
  // only speed mode clamps; other modes pass the command through untouched.
  // the command is registered, so it lags the input by one cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      speed_cmd_o <= 16'sh0000;
    end else if (spd_mode && mag16(analog_cmd_i) < {3'h0, zero_clamp_param_i}) begin
      speed_cmd_o <= 16'sh0000; // R6
    end else begin
      speed_cmd_o <= analog_cmd_i;
    end
  end

  // ****************************************
  // initial current bias
  // ****************************************
  // out of range settings saturate rather than wrap
  // a disabled drive holds no bias; a new setting takes effect on the next edge
  logic signed [7:0] bias_sat;
  always_comb begin
    bias_sat = initial_bias_param_i;
    if (initial_bias_param_i > sswm_pkg::SSWM_BIAS_MAX) begin
      bias_sat = sswm_pkg::SSWM_BIAS_MAX;
    end else if (initial_bias_param_i < sswm_pkg::SSWM_BIAS_MIN) begin
      bias_sat = sswm_pkg::SSWM_BIAS_MIN;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bias_o <= sswm_pkg::SSWM_BIAS_RST;
    end else begin
      bias_o <= enable_i ? bias_sat : 8'sh00; // R1
    end
  end

  // ****************************************
  // brake release delay
  // ****************************************
  // the first tick after enable may land on the very next edge, so the count
  // runs one past the setting: release comes n to n+1 ms after enable and
  // never early; one extra counter bit lets the largest setting still end
  logic [13:0] brake_dly_q;
  logic [14:0] brake_cnt_q;

  // the setting is only sampled while the servo is off
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      brake_dly_q <= sswm_pkg::SSWM_BRAKE_RST;
    end else if (!enable_i) begin
      brake_dly_q <= brake_release_delay_param_i; // R7
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      brake_cnt_q     <= 15'h0000;
      brake_release_o <= 1'b0;
    end else if (!enable_i) begin
      brake_cnt_q     <= 15'h0000;
      brake_release_o <= 1'b0;
    end else if (brake_dly_q == 14'h0000 || brake_cnt_q > {1'b0, brake_dly_q}) begin
      brake_release_o <= 1'b1; // R7
    end else if (ms_tick) begin
      brake_cnt_q <= brake_cnt_q + 15'h0001;
    end
  end

endmodule : sswm_monitor

// *** sswm_monitor_sva.sv ***
`timescale 1ns/10ps
// ****************************
// port checker
// ****************************
module sswm_chk (
  // clock and reset
  input wire logic                 sys_clk_i,
  input wire logic                 rst_i,
  // watched inputs
  input wire sswm_pkg::sswm_mode_t mode_i,
  input wire logic                 enable_i,
  input wire logic signed [31:0]   pos_err_i,
  input wire logic signed [15:0]   motor_speed_i,
  input wire logic signed [15:0]   analog_cmd_i,
  input wire logic signed [7:0]    initial_bias_param_i,
  input wire logic [11:0]          near_position_size_param_i,
  input wire logic [12:0]          up_to_speed_param_i,
  input wire logic [12:0]          zero_clamp_param_i,
  input wire logic                 near_pos_assigned_i,
  input wire logic                 uts_assigned_i,
  // watched outputs
  input wire logic                 in_position_o,
  input wire logic                 near_position_o,
  input wire logic                 within_window_o,
  input wire logic                 up_to_speed_o,
  input wire logic signed [15:0]   speed_cmd_o,
  input wire logic signed [7:0]    bias_o,
  input wire logic                 brake_release_o
);
  logic        live_q;
  logic [31:0] pe_a;
  logic [15:0] ac_a;
  logic [15:0] sp_a;
  // past values at the first edge after reset are reset-time ones
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) live_q <= 1'b0;
    else live_q <= 1'b1;
  end
  // magnitudes
  assign pe_a = pos_err_i[31] ? -pos_err_i : pos_err_i;
  assign ac_a = analog_cmd_i[15] ? -analog_cmd_i : analog_cmd_i;
  assign sp_a = motor_speed_i[15] ? -motor_speed_i : motor_speed_i;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i || !live_q);
  a_near_follow: assert property (near_position_o == $past(near_pos_assigned_i
    && mode_i == sswm_pkg::SSWM_MODE_POS && pe_a < 32'(near_position_size_param_i)))
    else $error("near position wrong");
  a_uts_follow: assert property (up_to_speed_o == $past(uts_assigned_i
    && sp_a > 16'(up_to_speed_param_i))) else $error("up to speed wrong");
  a_bias_off: assert property (!enable_i |=> bias_o == 8'sh00) else $error("bias when off");
  a_bias_live: assert property (enable_i && initial_bias_param_i inside {[-100:100]}
    |=> bias_o == $past(initial_bias_param_i)) else $error("bias not live");
  a_clamp_zero: assert property (mode_i == sswm_pkg::SSWM_MODE_SPEED
    && ac_a < 16'(zero_clamp_param_i) |=> speed_cmd_o == 16'sh0000) else $error("no clamp");
  a_cmd_pass: assert property (mode_i != sswm_pkg::SSWM_MODE_SPEED
    |=> speed_cmd_o == $past(analog_cmd_i)) else $error("command altered");
  a_brake_hold: assert property (!enable_i |=> !brake_release_o) else $error("brake off");
  a_inpos_mode: assert property (mode_i != sswm_pkg::SSWM_MODE_POS
    |=> !in_position_o) else $error("in position out of mode");
  a_win_mode: assert property (mode_i == sswm_pkg::SSWM_MODE_OTHER
    |=> !within_window_o) else $error("window out of mode");
  c_near: cover property ($rose(near_position_o));
  c_inpos: cover property ($rose(in_position_o));
  c_brake: cover property ($rose(brake_release_o));
endmodule : sswm_chk

// *** sswm_host.sv ***
`timescale 1ns/10ps
// host side: counts completed moves on the in-position line
module sswm_host (
  input  wire logic  sys_clk_i,
  input  wire logic  rst_i,
  input  wire logic  in_pos_i,
  output logic [7:0] moves_o
);
  logic seen_q;
  // edge detect so a long in-position level counts once
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seen_q  <= 1'b0;
      moves_o <= 8'h00;
    end else begin
      seen_q <= in_pos_i;
      if (in_pos_i && !seen_q) moves_o <= moves_o + 8'h01;
    end
  end
endmodule : sswm_host

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
  localparam int T = 5;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic enable_i, in_pos_assigned_i, near_pos_assigned_i, win_assigned_i, uts_assigned_i;
  sswm_pkg::sswm_mode_t mode_i;
  logic signed [31:0] pos_err_i;
  logic signed [15:0] speed_err_i, motor_speed_i, analog_cmd_i, speed_cmd_o;
  logic signed [7:0]  initial_bias_param_i, bias_o;
  logic [11:0] in_position_size_param_i, near_position_size_param_i;
  logic [9:0]  speed_window_param_i;
  logic [12:0] up_to_speed_param_i, zero_clamp_param_i;
  logic [13:0] brake_release_delay_param_i;
  logic in_position_o, near_position_o, within_window_o, up_to_speed_o, brake_release_o;
  logic [7:0] moves;
  int error_cnt = 0;
  int samples_checked = 0;
  sswm_monitor #(.TICK_CYC(T)) u_sswm_monitor (.*);
  sswm_host u_sswm_host (.sys_clk_i, .rst_i, .in_pos_i(in_position_o), .moves_o(moves));
  always #20 sys_clk_i = ~sys_clk_i;
  // ****************************
  // helpers
  // ****************************
  // outputs read right after an edge still hold the previous edge's values
  task automatic go(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : go
  task automatic wt(ref logic s, input int n);
    for (int k = 0; k < n && s !== 1'b1; k++) go(1);
  endtask : wt
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  // ****************************
  // scenarios
  // ****************************
  task automatic t_near();
    near_pos_assigned_i <= 1'b1;
    pos_err_i <= -32'sh0000_0013;
    go(2); chk(near_position_o, 1);
    pos_err_i <= 32'sh0000_0014;
    go(2); chk(near_position_o, 0);
    pos_err_i <= 32'sh0000_0013;
    mode_i <= sswm_pkg::SSWM_MODE_SPEED;
    go(2); chk(near_position_o, 0);
    mode_i <= sswm_pkg::SSWM_MODE_POS;
    near_pos_assigned_i <= 1'b0;
    go(2); chk(near_position_o, 0);
  endtask : t_near
  task automatic t_inpos();
    in_pos_assigned_i <= 1'b1;
    pos_err_i <= 32'sh0000_0009;
    go(sswm_pkg::SSWM_INPOS_MS * T + 1); chk(in_position_o, 0);
    wt(in_position_o, 2 * T + 4); chk(in_position_o, 1);
    pos_err_i <= 32'sh0000_000a;
    go(2); chk(in_position_o, 0);
    pos_err_i <= 32'sh0000_0400;
  endtask : t_inpos
  task automatic t_win();
    win_assigned_i <= 1'b1;
    mode_i <= sswm_pkg::SSWM_MODE_SPEED;
    speed_err_i <= -16'sh0009;
    go(sswm_pkg::SSWM_WIN_MS * T + 1); chk(within_window_o, 0);
    wt(within_window_o, 3 * T + 4); chk(within_window_o, 1);
    mode_i <= sswm_pkg::SSWM_MODE_OTHER;
    go(2); chk(within_window_o, 0);
    mode_i <= sswm_pkg::SSWM_MODE_TORQUE;
    go(sswm_pkg::SSWM_WIN_MS * T + 1); chk(within_window_o, 0);
    wt(within_window_o, 3 * T + 4); chk(within_window_o, 1);
  endtask : t_win
  task automatic t_uts();
    uts_assigned_i <= 1'b1;
    mode_i <= sswm_pkg::SSWM_MODE_OTHER;
    motor_speed_i <= 16'sh0015;
    go(2); chk(up_to_speed_o, 1);
    motor_speed_i <= -16'sh0015;
    go(2); chk(up_to_speed_o, 1);
    motor_speed_i <= 16'sh0014;
    go(2); chk(up_to_speed_o, 0);
  endtask : t_uts
  task automatic t_clamp();
    mode_i <= sswm_pkg::SSWM_MODE_SPEED;
    zero_clamp_param_i <= 13'h0032;
    analog_cmd_i <= -16'sh0031;
    go(2); chk(speed_cmd_o, 16'h0000);
    analog_cmd_i <= -16'sh0032;
    go(2); chk(speed_cmd_o, -16'sh0032);
    mode_i <= sswm_pkg::SSWM_MODE_POS;
    analog_cmd_i <= -16'sh0031;
    go(2); chk(speed_cmd_o, -16'sh0031);
  endtask : t_clamp
  task automatic t_bias();
    initial_bias_param_i <= -8'sh64;
    go(2); chk(bias_o, 16'h0000);
    enable_i <= 1'b1;
    go(2); chk(bias_o, 16'hff9c);
    initial_bias_param_i <= 8'sh25;
    go(2); chk(bias_o, 16'h0025);
    initial_bias_param_i <= 8'sh7f;
    go(2); chk(bias_o, 16'h0064);
    enable_i <= 1'b0;
  endtask : t_bias
  task automatic t_brake();
    brake_release_delay_param_i <= 14'h0003;
    go(2); enable_i <= 1'b1;
    go(1); brake_release_delay_param_i <= 14'h0000;
    go(3 * T); chk(brake_release_o, 0);
    wt(brake_release_o, 3 * T + 4); chk(brake_release_o, 1);
    enable_i <= 1'b0;
    go(2); chk(brake_release_o, 0);
    enable_i <= 1'b1;
    go(3); chk(brake_release_o, 1);
  endtask : t_brake
  // main sequence, inputs idle and at their defaults from time zero
  initial begin
    {enable_i, in_pos_assigned_i, near_pos_assigned_i, win_assigned_i, uts_assigned_i} = '0;
    mode_i = sswm_pkg::SSWM_MODE_POS;
    pos_err_i = 32'sh0000_0400;
    speed_err_i = 16'sh0400;
    motor_speed_i = 16'sh0000;
    analog_cmd_i = 16'sh0000;
    initial_bias_param_i = sswm_pkg::SSWM_BIAS_RST;
    in_position_size_param_i = sswm_pkg::SSWM_INPOS_RST;
    near_position_size_param_i = sswm_pkg::SSWM_NEAR_RST;
    speed_window_param_i = sswm_pkg::SSWM_WIN_RST;
    up_to_speed_param_i = sswm_pkg::SSWM_UTS_RST;
    zero_clamp_param_i = sswm_pkg::SSWM_CLAMP_RST;
    brake_release_delay_param_i = sswm_pkg::SSWM_BRAKE_RST;
    go(10); rst_i <= 1'b0;
    go(2); chk({in_position_o, near_position_o, within_window_o, brake_release_o, bias_o}, 0);
    t_near();
    t_inpos();
    t_win();
    t_uts();
    t_clamp();
    t_bias();
    t_brake();
    chk(moves, 1);
    test_done();
  end
  // watchdog well past the few hundred cycles the tests need
  initial begin
    go(5000);
    error_cnt++;
    test_done();
  end
endmodule : tb
bind sswm_monitor sswm_chk u_sswm_chk (.*);
